// file: core/lsag_consts.svh
// Constants for the indexed load/store address generator
`ifndef LSAG_CONSTS_SVH
`define LSAG_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------------
`define LSAG_COND_HI      31
`define LSAG_COND_LO      28
`define LSAG_CLASS_HI     27
`define LSAG_CLASS_LO     26
`define LSAG_REGOFS_BIT   25
`define LSAG_PRE_BIT      24
`define LSAG_SIGN_BIT     23
`define LSAG_BYTE_BIT     22
`define LSAG_WB_BIT       21
`define LSAG_LOAD_BIT     20
`define LSAG_BASE_HI      19
`define LSAG_BASE_LO      16
`define LSAG_XFER_HI      15
`define LSAG_XFER_LO      12
`define LSAG_IMM_HI       11
`define LSAG_IMM_LO       0
`define LSAG_SHAMT_HI     11
`define LSAG_SHAMT_LO     7
`define LSAG_SHTYPE_HI    6
`define LSAG_SHTYPE_LO    5
`define LSAG_ZERO_BIT     4
`define LSAG_INDEX_HI     3
`define LSAG_INDEX_LO     0

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define LSAG_CLASS_LDST   2'h1
`define LSAG_PC_REG       4'hf
`define LSAG_RST_ADDR     32'h0000_0000

`endif

// file: core/lsag_pkg.sv
// Types for the indexed load/store address generator
package lsag_pkg;

    // Index shift kinds
    typedef enum logic [1:0] {
        LSAG_SHIFT_LEFT_LOGICAL,
        LSAG_SHIFT_RIGHT_LOGICAL,
        LSAG_SHIFT_RIGHT_ARITH,
        LSAG_ROTATE_RIGHT
    } lsag_shift_t;

    // Issue sequencing states
    typedef enum logic [1:0] {
        LSAG_IDLE,
        LSAG_ACCESS,
        LSAG_WRITEBACK
    } lsag_state_t;

endpackage : lsag_pkg

// file: core/lsag_cond_eval.sv
// Condition field evaluator against the current flags
`timescale 1ns/10ps

module lsag_cond_eval (
    input  wire logic [3:0] cond,
    input  wire logic       flag_n,
    input  wire logic       flag_z,
    input  wire logic       flag_c,
    input  wire logic       flag_v,
    output logic            condition_check
);

    // ------------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------------
    // Standard sixteen-way table; code 4'hf treated as never
    always_comb begin
        case (cond)
            4'h0:    condition_check = flag_z;
            4'h1:    condition_check = !flag_z;
            4'h2:    condition_check = flag_c;
            4'h3:    condition_check = !flag_c;
            4'h4:    condition_check = flag_n;
            4'h5:    condition_check = !flag_n;
            4'h6:    condition_check = flag_v;
            4'h7:    condition_check = !flag_v;
            4'h8:    condition_check = flag_c && !flag_z;
            4'h9:    condition_check = !flag_c || flag_z;
            4'ha:    condition_check = (flag_n == flag_v);
            4'hb:    condition_check = (flag_n != flag_v);
            4'hc:    condition_check = !flag_z && (flag_n == flag_v);
            4'hd:    condition_check = flag_z || (flag_n != flag_v);
            4'he:    condition_check = 1'b1;
            default: condition_check = 1'b0;
        endcase
    end

endmodule : lsag_cond_eval

// file: core/lsag_index_shifter.sv
// Index register barrel shifter for scaled offsets
`timescale 1ns/10ps

module lsag_index_shifter
    import lsag_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] index_val,
    input  wire logic [1:0]       shift_type,
    input  wire logic [4:0]       shift_amt,
    input  wire logic             carry_in,
    output logic      [WIDTH-1:0] index_out
);

    lsag_shift_t kind;

    // ------------------------------------------------------------------
    // Shift and rotate
    // ------------------------------------------------------------------
    // A zero right-shift amount encodes a full-width shift (a one-bit rotate through
    // carry for rotate), so zero amounts are special-cased for the three right kinds
    always_comb begin
        kind = lsag_shift_t'(shift_type);
        case (kind)
            LSAG_SHIFT_LEFT_LOGICAL:
                index_out = index_val << shift_amt;
            LSAG_SHIFT_RIGHT_LOGICAL:
                index_out = (shift_amt == 5'h0) ? '0
                          : index_val >> shift_amt;
            LSAG_SHIFT_RIGHT_ARITH:
                index_out = (shift_amt == 5'h0)
                          ? {WIDTH{index_val[WIDTH-1]}}
                          : WIDTH'($signed(index_val) >>> shift_amt);
            LSAG_ROTATE_RIGHT:
                index_out = (shift_amt == 5'h0)
                          ? {carry_in, index_val[WIDTH-1:1]}
                          : WIDTH'({index_val, index_val} >> shift_amt);
            default:
                index_out = index_val;
        endcase
    end

endmodule : lsag_index_shifter

// file: core/lsag_addr_gen.sv
// Indexed load/store address generation and base writeback
`timescale 1ns/10ps

`include "lsag_consts.svh"

module lsag_addr_gen
    import lsag_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    input  wire logic             instr_valid,
    input  wire logic [31:0]      instr,
    input  wire logic [WIDTH-1:0] base_val,
    input  wire logic [WIDTH-1:0] index_val,
    input  wire logic             flag_n,
    input  wire logic             flag_z,
    input  wire logic             flag_c,
    input  wire logic             flag_v,
    input  wire logic             mem_ready,
    output logic                  instr_ready,
    output logic [3:0]            base_reg,
    output logic [3:0]            index_reg,
    output logic                  mem_req,
    output logic [WIDTH-1:0]      mem_addr,
    output logic                  mem_byte,
    output logic                  mem_load,
    output logic                  mem_user,
    output logic [3:0]            mem_xfer_reg,
    output logic                  base_wr_en,
    output logic [3:0]            base_wr_reg,
    output logic [WIDTH-1:0]      base_wr_data,
    output logic                  decode_err,
    output logic                  unpredictable
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [WIDTH-1:0] add_sub(
        input logic [WIDTH-1:0] a,
        input logic [WIDTH-1:0] b,
        input logic             up
    );
        add_sub = up ? WIDTH'(a + b) : WIDTH'(a - b);
    endfunction : add_sub

    logic             cond_ok;
    logic             is_ldst;
    logic             is_pre;
    logic             is_post;
    logic             reg_ofs;
    logic             up;
    logic [WIDTH-1:0] shifted;
    logic [WIDTH-1:0] offset;
    logic [WIDTH-1:0] pre_addr;
    logic [WIDTH-1:0] new_base;
    logic             fmt_ok;
    logic             bad_ops;

    assign base_reg  = instr[`LSAG_BASE_HI:`LSAG_BASE_LO];
    assign index_reg = instr[`LSAG_INDEX_HI:`LSAG_INDEX_LO];

    lsag_cond_eval u_cond (
        .cond            (instr[`LSAG_COND_HI:`LSAG_COND_LO]),
        .flag_n          (flag_n),
        .flag_z          (flag_z),
        .flag_c          (flag_c),
        .flag_v          (flag_v),
        .condition_check (cond_ok)
    );

    lsag_index_shifter #(.WIDTH(WIDTH)) u_shift (
        .index_val  (index_val),
        .shift_type (instr[`LSAG_SHTYPE_HI:`LSAG_SHTYPE_LO]),
        .shift_amt  (instr[`LSAG_SHAMT_HI:`LSAG_SHAMT_LO]),
        .carry_in   (flag_c),
        .index_out  (shifted)
    );

    // ------------------------------------------------------------------
    // Form classification and offset arithmetic
    // ------------------------------------------------------------------
    // Offset-only forms (P=1, W=0) fall in neither class and are refused
    always_comb begin
        is_ldst = instr[`LSAG_CLASS_HI:`LSAG_CLASS_LO] == `LSAG_CLASS_LDST;
        is_pre  = instr[`LSAG_PRE_BIT] && instr[`LSAG_WB_BIT];
        is_post = !instr[`LSAG_PRE_BIT];
        reg_ofs = instr[`LSAG_REGOFS_BIT];
        up      = instr[`LSAG_SIGN_BIT];
        // Register offset needs bit 4 clear; the plain index form is just
        // a left shift by zero, so it falls through the shifter
        fmt_ok  = is_ldst && (is_pre || is_post)
                && !(reg_ofs && instr[`LSAG_ZERO_BIT]);
        offset  = reg_ofs ? shifted
                : WIDTH'(instr[`LSAG_IMM_HI:`LSAG_IMM_LO]);
        pre_addr = add_sub(base_val, offset, up);
        new_base = pre_addr;
        // Flag operand hazards the instruction source must avoid
        bad_ops = (base_reg == `LSAG_PC_REG)
                || (reg_ofs && (index_reg == `LSAG_PC_REG))
                || (reg_ofs && (index_reg == base_reg));
    end

    // ------------------------------------------------------------------
    // Issue sequencer
    // ------------------------------------------------------------------
    lsag_state_t      state_q, state_d;
    logic             req_q, req_d;
    logic [WIDTH-1:0] addr_q, addr_d;
    logic             byte_q, byte_d;
    logic             load_q, load_d;
    logic             user_q, user_d;
    logic [3:0]       xfer_q, xfer_d;
    logic             wb_q, wb_d;
    logic [3:0]       wbreg_q, wbreg_d;
    logic [WIDTH-1:0] wbdata_q, wbdata_d;
    logic             err_q, err_d;
    logic             unp_q, unp_d;
    logic             take;

    // Accept only while idle; holding decoded values keeps the memory
    // side stable across a stalled access
    assign take = clk_en && instr_valid && (state_q == LSAG_IDLE);
    assign instr_ready = (state_q == LSAG_IDLE);

    always_comb begin
        state_d  = state_q;
        req_d    = req_q;
        addr_d   = addr_q;
        byte_d   = byte_q;
        load_d   = load_q;
        user_d   = user_q;
        xfer_d   = xfer_q;
        wb_d     = 1'b0;
        wbreg_d  = wbreg_q;
        wbdata_d = wbdata_q;
        err_d    = 1'b0;
        unp_d    = 1'b0;
        case (state_q)
            LSAG_IDLE: begin
                if (instr_valid) begin
                    unp_d = fmt_ok && bad_ops;
                    if (!fmt_ok) begin
                        err_d = 1'b1;
                    end else if (cond_ok) begin
                        req_d   = 1'b1;
                        // Post forms address at the raw base
                        addr_d  = is_pre ? pre_addr
                                : base_val;
                        byte_d  = instr[`LSAG_BYTE_BIT];
                        load_d  = instr[`LSAG_LOAD_BIT];
                        user_d  = is_post && instr[`LSAG_WB_BIT];
                        xfer_d  = instr[`LSAG_XFER_HI:`LSAG_XFER_LO];
                        wbreg_d = base_reg;
                        wbdata_d = new_base;
                        state_d = LSAG_ACCESS;
                    end
                    // Failed condition: nothing issued, nothing written
                end
            end
            LSAG_ACCESS: begin
                if (mem_ready) begin
                    req_d   = 1'b0;
                    state_d = LSAG_WRITEBACK;
                end
            end
            LSAG_WRITEBACK: begin
                // Base update only after a passed, completed access
                wb_d    = 1'b1;
                state_d = LSAG_IDLE;
            end
            default: begin
                state_d = LSAG_IDLE;
                req_d   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q  <= LSAG_IDLE;
            req_q    <= 1'b0;
            addr_q   <= `LSAG_RST_ADDR;
            byte_q   <= 1'b0;
            load_q   <= 1'b0;
            user_q   <= 1'b0;
            xfer_q   <= 4'h0;
            wb_q     <= 1'b0;
            wbreg_q  <= 4'h0;
            wbdata_q <= `LSAG_RST_ADDR;
            err_q    <= 1'b0;
            unp_q    <= 1'b0;
        end else if (clk_en) begin
            state_q  <= state_d;
            req_q    <= req_d;
            addr_q   <= addr_d;
            byte_q   <= byte_d;
            load_q   <= load_d;
            user_q   <= user_d;
            xfer_q   <= xfer_d;
            wb_q     <= wb_d;
            wbreg_q  <= wbreg_d;
            wbdata_q <= wbdata_d;
            err_q    <= err_d;
            unp_q    <= unp_d;
        end
    end

    assign mem_req       = req_q;
    assign mem_addr      = addr_q;
    assign mem_byte      = byte_q;
    assign mem_load      = load_q;
    assign mem_user      = user_q;
    assign mem_xfer_reg  = xfer_q;
    assign base_wr_en    = wb_q;
    assign base_wr_reg   = wbreg_q;
    assign base_wr_data  = wbdata_q;
    assign decode_err    = err_q;
    assign unpredictable = unp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    pre_imm_addr_a: assert property (
        (take && fmt_ok && cond_ok && is_pre && !reg_ofs)
        |=> mem_req && mem_addr == ($past(instr[23])
            ? WIDTH'($past(base_val) + $past(instr[11:0]))
            : WIDTH'($past(base_val) - $past(instr[11:0]))))
        else $error("pre-index immediate address wrong");
    pre_reg_addr_a: assert property (
        (take && fmt_ok && cond_ok && is_pre && reg_ofs)
        |=> mem_addr == ($past(up)
            ? WIDTH'($past(base_val) + $past(shifted))
            : WIDTH'($past(base_val) - $past(shifted))))
        else $error("pre-index register address wrong");
    post_addr_a: assert property (
        (take && fmt_ok && cond_ok && is_post)
        |=> mem_addr == $past(base_val))
        else $error("post-index address not raw base");
    post_wb_data_a: assert property (
        (take && fmt_ok && cond_ok && is_post)
        |=> base_wr_data == ($past(up)
            ? WIDTH'($past(base_val) + $past(offset))
            : WIDTH'($past(base_val) - $past(offset))))
        else $error("post-index writeback value wrong");
    cond_fail_quiet_a: assert property (
        (take && !cond_ok) |=> !mem_req ##1 !base_wr_en)
        else $error("failed condition caused activity");
    wb_after_access_a: assert property (
        $rose(base_wr_en) |-> $past(state_q, 1) == LSAG_WRITEBACK)
        else $error("writeback without access");
    byte_load_a: assert property (
        (take && fmt_ok && cond_ok) |=> mem_byte == $past(instr[22])
        && mem_load == $past(instr[20]))
        else $error("byte or load select wrong");
    user_mode_a: assert property (
        (take && fmt_ok && cond_ok)
        |=> mem_user == (!$past(instr[24]) && $past(instr[21])))
        else $error("user access flag wrong");
    unp_flag_a: assert property (
        (take && fmt_ok && (instr[19:16] == 4'hf
            || (instr[25] && instr[3:0] == instr[19:16])))
        |=> unpredictable)
        else $error("operand hazard not flagged");
    bad_form_a: assert property (
        (take && instr[24] && !instr[21]) |=> decode_err && !mem_req)
        else $error("offset-only form not refused");

    pre_cov_c:  cover property (take && fmt_ok && cond_ok && is_pre);
    post_cov_c: cover property (take && fmt_ok && cond_ok && is_post);
    fail_cov_c: cover property (take && fmt_ok && !cond_ok);
    stall_cov_c: cover property (mem_req && !mem_ready ##1 mem_req);

endmodule : lsag_addr_gen

// file: verification/lsag_partner.sv
// Register file and memory port model facing the address generator
`timescale 1ns/10ps

module lsag_partner (
    input  wire logic        clk,
    input  wire logic        clk_en,
    input  wire logic        slow,
    input  wire logic [3:0]  base_reg,
    input  wire logic [3:0]  index_reg,
    input  wire logic        mem_req,
    input  wire logic        base_wr_en,
    input  wire logic [3:0]  base_wr_reg,
    input  wire logic [31:0] base_wr_data,
    output logic      [31:0] base_val,
    output logic      [31:0] index_val,
    output logic             mem_ready
);
    logic [31:0] regs [16];
    int          seed = 32'h4378;

    // Known spread of start values so every lookup differs
    initial begin
        for (int i = 0; i < 16; i++) begin
            regs[i] = 32'h0001_0000 * i + 32'h0000_0840;
        end
        mem_ready = 1'b0;
    end

    // Read ports are combinational and write-first: a base update still
    // pending at this edge is seen by a new instruction taken at it
    assign base_val  = (base_wr_en && base_wr_reg == base_reg)
                     ? base_wr_data : regs[base_reg];
    assign index_val = (base_wr_en && base_wr_reg == index_reg)
                     ? base_wr_data : regs[index_reg];

    // Base update lands only on enabled edges
    always @(posedge clk) begin
        if (clk_en && base_wr_en) begin
            regs[base_wr_reg] <= base_wr_data;
        end
    end

    // Memory answers at once or after random stalls
    always @(negedge clk) begin
        mem_ready <= mem_req && (!slow || ($random(seed) % 3 == 0));
    end
endmodule : lsag_partner

// file: verification/ldst_indexed_addr_gen_tb.sv
// Self-checking bench for the indexed load/store address generator
`timescale 1ns/10ps

module ldst_indexed_addr_gen_tb;
    import lsag_pkg::*;

    typedef struct packed {
        logic [1:0]  kind;
        logic [31:0] val;
        logic [3:0]  rnum;
        logic [2:0]  attr;
    } lsag_note_t;

    logic        clk, nrst, clk_en, instr_valid, mem_ready, slow, jitter;
    logic        flag_n, flag_z, flag_c, flag_v, instr_ready, mem_req;
    logic        mem_byte, mem_load, mem_user, base_wr_en, decode_err;
    logic        unpredictable;
    logic [31:0] instr, base_val, index_val, mem_addr, base_wr_data;
    logic [3:0]  base_reg, index_reg, mem_xfer_reg, base_wr_reg;
    logic [31:0] mirror [16];
    logic [3:0]  conds [4] = '{4'he, 4'he, 4'h0, 4'hf};
    lsag_note_t  notes [$];
    int          seed = 32'h4378;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;

    lsag_addr_gen #(.WIDTH(32)) lsag_addr_gen_inst (
        .clk(clk), .nrst(nrst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr(instr),
        .base_val(base_val), .index_val(index_val),
        .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c),
        .flag_v(flag_v), .mem_ready(mem_ready),
        .instr_ready(instr_ready), .base_reg(base_reg),
        .index_reg(index_reg), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_byte(mem_byte), .mem_load(mem_load), .mem_user(mem_user),
        .mem_xfer_reg(mem_xfer_reg), .base_wr_en(base_wr_en),
        .base_wr_reg(base_wr_reg), .base_wr_data(base_wr_data),
        .decode_err(decode_err), .unpredictable(unpredictable)
    );

    lsag_partner lsag_partner_inst (
        .clk(clk), .clk_en(clk_en), .slow(slow), .base_reg(base_reg),
        .index_reg(index_reg), .mem_req(mem_req),
        .base_wr_en(base_wr_en), .base_wr_reg(base_wr_reg),
        .base_wr_data(base_wr_data), .base_val(base_val),
        .index_val(index_val), .mem_ready(mem_ready)
    );

    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Random freeze cycles, always enabled while in reset
    always @(negedge clk) begin
        clk_en <= jitter ? ($random(seed) % 4 != 0) : 1'b1;
    end

    // Hang guard, well above the thousand or so cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Oldest note must match the event just seen
    task automatic take(input lsag_note_t s);
        lsag_note_t e;
        if (notes.size() == 0) begin
            check("event with nothing pending", 32'h1, 32'h0);
            return;
        end
        e = notes.pop_front();
        check("event kind", 32'(s.kind), 32'(e.kind));
        check("value", s.val, e.val);
        check("register", 32'(s.rnum), 32'(e.rnum));
        check("byte load user", 32'(s.attr), 32'(e.attr));
    endtask : take

    // Watch outputs on enabled edges only; frozen edges count nothing
    always @(posedge clk) begin
        if (nrst && clk_en) begin
            if (unpredictable) take('{2'h0, 32'h0, 4'h0, 3'h0});
            if (mem_req && mem_ready) begin
                take('{2'h1, mem_addr, mem_xfer_reg,
                       {mem_byte, mem_load, mem_user}});
            end
            if (base_wr_en) take('{2'h2, base_wr_data, base_wr_reg, 3'h0});
            if (decode_err) take('{2'h3, 32'h0, 4'h0, 3'h0});
        end
    end

    // Index shifter; zero right shifts mean full width, zero rotate
    // is the one-bit rotate through carry
    function automatic logic [31:0] shifted(input logic [31:0] v,
        input logic [1:0] t, input logic [4:0] a, input logic c);
        case (t)
            2'h0: return v << a;
            2'h1: return (a == 5'h0) ? 32'h0 : v >> a;
            2'h2: begin
                if (a == 5'h0) return {32{v[31]}};
                return $signed(v) >>> a;
            end
            default: return (a == 5'h0) ? {c, v[31:1]}
                                        : (v >> a) | (v << (6'd32 - a));
        endcase
    endfunction : shifted

    // Forms: 0-2 pre imm/reg/scaled, 3-5 post, 6 user post, 7-9 bad
    task automatic exec(input int form, input logic [3:0] cond,
                        input logic [3:0] rn, input logic [3:0] rm);
        logic [31:0] off, upd, adr;
        logic [11:0] ofs;
        logic [4:0]  amt;
        logic [1:0]  typ;
        logic [3:0]  rd;
        logic        u, b, l, z, c, pre, rg, w, usr, unp, pass;
        int          n;
        {u, b, l, z, c} = 5'($random(seed));
        {ofs, amt, typ, rd} = 23'($random(seed));
        pre = form < 3 || form == 7;
        rg = form inside {1, 2, 4, 5, 8};
        usr = form == 6;
        w = (pre && form != 7) || usr;
        if (form == 1 || form == 4) {amt, typ} = 7'h00;
        off = rg ? shifted(mirror[rm], typ, amt, c) : {20'h0, ofs};
        upd = u ? mirror[rn] + off : mirror[rn] - off;
        adr = pre ? upd : mirror[rn];
        pass = cond == 4'he || (cond == 4'h0 && z);
        unp = rn == 4'hf || (rg && (rm == 4'hf || rm == rn));
        instr <= {cond, (form == 9) ? 2'h0 : 2'h1, rg, pre, u, b, w, l,
                  rn, rd, rg ? {amt, typ, form == 8, rm} : ofs};
        {flag_n, flag_v} <= 2'($random(seed));
        flag_z <= z;
        flag_c <= c;
        instr_valid <= 1'b1;
        if (form >= 7) begin
            notes.push_back('{2'h3, 32'h0, 4'h0, 3'h0});
        end else if (pass) begin
            if (unp) notes.push_back('{2'h0, 32'h0, 4'h0, 3'h0});
            notes.push_back('{2'h1, adr, rd, {b, l, usr}});
            notes.push_back('{2'h2, upd, rn, 3'h0});
            mirror[rn] = upd;
        end
        n = 0;
        while (!(instr_ready && clk_en) && n < 50) begin
            @(negedge clk) #1;
            n++;
        end
        @(negedge clk) #1;
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk) #1;
            n++;
        end while (!instr_ready && n < 200);
    endtask : exec

    // Reset, random traffic, refused encodings, operand hazards
    initial begin
        logic [3:0] rn, rm;
        logic [1:0] sel;
        {nrst, instr_valid, slow, jitter} = 4'b0000;
        {flag_n, flag_z, flag_c, flag_v} = 4'h0;
        instr = 32'h0;
        for (int i = 0; i < 16; i++) begin
            mirror[i] = 32'h0001_0000 * i + 32'h0000_0840;
        end
        repeat (10) @(negedge clk);
        nrst <= 1'b1;
        #1;
        for (int k = 0; k < 280; k++) begin
            rn = 4'($random(seed));
            if (rn == 4'hf) rn = 4'h0;
            rm = 4'($random(seed));
            // Keep the index off the program counter and off the base
            if (rm == 4'hf || rm == rn) begin
                rm = (rn == 4'h0) ? 4'h1 : 4'h0;
            end
            sel = 2'($random(seed));
            slow <= k[0];
            jitter <= k >= 140;
            exec(k % 7, conds[sel], rn, rm);
        end
        jitter <= 1'b0;
        for (int f = 7; f < 10; f++) exec(f, 4'he, 4'h2, 4'h3);
        exec(0, 4'he, 4'hf, 4'h1);
        exec(4, 4'he, 4'h3, 4'hf);
        exec(5, 4'he, 4'h5, 4'h5);
        repeat (4) @(negedge clk);
        check("notes left over", 32'(notes.size()), 32'h0);
        give_verdict();
    end
endmodule : ldst_indexed_addr_gen_tb
